// File: src/eectl_consts.vh
`ifndef EECTL_CONSTS_VH
`define EECTL_CONSTS_VH
// ==================================================
// Register indexes (4-byte control block)
`define REG_MODULE_CONFIG   2'h0
`define REG_BLOCK_PROTECT   2'h1
`define REG_TEST_CONTROL    2'h2
`define REG_PROGRAM_CONTROL 2'h3
// ==================================================
// module_config fields
`define MC_WAIT_STOP   7
`define MC_PROT_LOCK   2
`define MC_PUMP_CLK    0
// ==================================================
// test_control fields
`define TC_ODD_ROW     7
`define TC_EVEN_ROW    6
`define TC_MARGIN      5
`define TC_PUMP_DIS    4
`define TC_RAMP_DIS    3
`define TC_MONITOR     2
`define TC_MASK        8'hfc
// ==================================================
// program_control fields
`define PC_BULK_PROT   7
`define PC_BYTE_SEL    4
`define PC_ROW_SEL     3
`define PC_ERASE       2
`define PC_LATCH       1
`define PC_PROGRAM     0
`define PC_MASK        8'h9f
// ==================================================
// Reset values
`define MC_RESET       8'h00
`define BP_RESET       8'h7f
`define TC_RESET       8'h00
`define PC_RESET       8'h80
// ==================================================
// Array map (12-bit offset within 4096 bytes)
`define ARR_AW         12
`define REG_BP6_BASE   12'h000
`define REG_BP5_BASE   12'h800
`define REG_BP4_BASE   12'hc00
`define REG_BP3_BASE   12'he00
`define REG_BP2_BASE   12'hf00
`define REG_BP1_BASE   12'hf80
`define REG_BP0_BASE   12'hfc0
// ==================================================
// Erase sizes
`define ERASE_BULK     2'h0
`define ERASE_ROW      2'h1
`define ERASE_BYTE     2'h2
`define ERASE_NONE     2'h3
// Pump ramp length in clk_en steps
`define RAMP_STEPS     4'hf
`endif

// File: src/pump_ramp.v
`timescale 1ns/100ps
// ==================================================
// Charge pump progressive ramp-up
`include "eectl_consts.vh"
module pump_ramp (
   input  wire       clk,
   input  wire       rstn,
   input  wire       clk_en,
   input  wire       pump_on,
   input  wire       ramp_disable,
   output reg  [3:0] level
);
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         level <= 4'h0;
      end else if (!pump_on) begin
         level <= 4'h0;
      end else if (ramp_disable) begin
         level <= `RAMP_STEPS; // [RL10]
      end else if (clk_en && level != `RAMP_STEPS) begin
         level <= level + 4'h1; // [RL10]
      end
   end
endmodule // pump_ramp

// File: src/eeprom_program_erase_control.v
// Functional notes
// RL1: Wait-stop bit set stops module clocking in wait mode; clear means unaffected.
// RL2: Protect lock freezes block protect and bulk protect; write-once in normal modes.
// RL3: Pump clock select 1 uses RC oscillator; 0 uses system clock, RC stopped.
// RL4: Block protect writes accepted only when program enable and lock are 0.
// RL5: Seven protect bits each guard one array region, 2048 down to 64 bytes.
// RL6: Test bits writable only in special modes; forced to 0 in normal modes.
// RL7: Odd/even row bits make bulk operations act on odd or even rows.
// RL8: Margin test bit selects margin test program/erase.
// RL9: Pump disable keeps pump off; otherwise pump on during program or erase.
// RL10: Ramp disable 0 ramps pump progressively; 1 skips ramp.
// RL11: Bulk protect refuses bulk and row erase; writable only when enable and lock 0.
// RL12: Byte/row select: 00 bulk, 01 row of 32 bytes, byte 1 byte/word.
// RL13: Erase bit selects erase; when 0 byte and row select have no effect.
// RL14: Byte erase outside test acts on latched address only, byte or aligned word.
// RL15: Latch enable blocks array reads; array writes then load address/data latches.
// RL16: Program enable sets only if latch already set; both together set latch only.
// RL17: While program enable, bulk protect, selects, erase and latch are frozen.
// RL18: While program enable, array writes ignored; latches held.
// RL19: Selects, erase, latch writable together or in any order when enable is 0.
// RL20: Software clears program enable, then latch enable, before reading.
// RL21: Software sequence: mode+latch, array write, enable, wait, clear enable, clear latch.
// RL22: Repeated operations without clearing latch enable are supported.
// RL23: Misaligned word write while latching latches only the lower byte.
// RL24: Stop mode removes program voltage and RC clock, keeps program enable.
// RL25: Pump enable output when programming, pump enabled and target unprotected.
`timescale 1ns/100ps
`include "eectl_consts.vh"
module eeprom_program_erase_control (
   input  wire        clk,
   input  wire        rstn,
   input  wire        special_mode_n,
   input  wire        wait_mode,
   input  wire        stop_mode,
   input  wire        ramp_tick,
   input  wire        reg_sel,
   input  wire [1:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   input  wire        arr_wr,
   input  wire        arr_rd,
   input  wire [11:0] arr_addr,
   input  wire        arr_word,
   input  wire [15:0] arr_wdata,
   output reg         arr_read_ok,
   output reg  [11:0] latch_addr,
   output reg  [15:0] latch_data,
   output reg         latch_word,
   output reg         latch_valid,
   output reg         module_clk_en,
   output reg         rc_osc_en,
   output reg         pump_clk_rc,
   output reg         pump_enable,
   output reg  [3:0]  pump_level,
   output reg         erase_mode,
   output reg  [1:0]  erase_size,
   output reg         odd_row_bulk,
   output reg         even_row_bulk,
   output reg         margin_test,
   output reg         pump_monitor,
   output reg         target_protected
);
   // ==================================================
   // Registers
   reg  [7:0] module_config_reg;
   reg  [7:0] block_protect_reg;
   reg  [7:0] test_control_reg;
   reg  [7:0] program_control_reg;
   reg        lock_written_reg;
   reg  [7:0] module_config_next;
   reg  [7:0] block_protect_next;
   reg  [7:0] test_control_next;
   reg  [7:0] program_control_next;
   wire [3:0] ramp_level;

   // ==================================================
   // Pin synchronisers (mode strobes come from pins)
   reg  [2:0] smod_sync;
   reg  [2:0] wait_sync;
   reg  [2:0] stop_sync;
   reg        smod_n;
   reg        in_wait;
   reg        in_stop;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         smod_sync <= 3'h7;
         wait_sync <= 3'h0;
         stop_sync <= 3'h0;
         smod_n    <= 1'b1;
         in_wait   <= 1'b0;
         in_stop   <= 1'b0;
      end else begin
         smod_sync <= {smod_sync[1:0], special_mode_n};
         wait_sync <= {wait_sync[1:0], wait_mode};
         stop_sync <= {stop_sync[1:0], stop_mode};
         if (smod_sync[1] == smod_sync[2]) smod_n <= smod_sync[2];
         if (wait_sync[1] == wait_sync[2]) in_wait <= wait_sync[2];
         if (stop_sync[1] == stop_sync[2]) in_stop <= stop_sync[2];
      end
   end

   // ==================================================
   // Decode helpers
   function in_range;
      input [11:0] a;
      input [11:0] lo;
      input [11:0] hi;
      begin
         in_range = a >= lo && a < hi;
      end
   endfunction

   function [6:0] region_hit;
      input [11:0] a;
      begin
         region_hit[6] = a < `REG_BP5_BASE;
         region_hit[5] = in_range(a, `REG_BP5_BASE, `REG_BP4_BASE);
         region_hit[4] = in_range(a, `REG_BP4_BASE, `REG_BP3_BASE);
         region_hit[3] = in_range(a, `REG_BP3_BASE, `REG_BP2_BASE);
         region_hit[2] = in_range(a, `REG_BP2_BASE, `REG_BP1_BASE);
         region_hit[1] = in_range(a, `REG_BP1_BASE, `REG_BP0_BASE);
         region_hit[0] = a >= `REG_BP0_BASE;
      end
   endfunction

   function [1:0] size_of;
      input [7:0] pc;
      begin
         if (!pc[`PC_ERASE])
            size_of = `ERASE_NONE; // [RL13]
         else if (pc[`PC_BYTE_SEL])
            size_of = `ERASE_BYTE; // [RL12]
         else if (pc[`PC_ROW_SEL])
            size_of = `ERASE_ROW; // [RL12]
         else
            size_of = `ERASE_BULK; // [RL12]
      end
   endfunction

   function wr_hit;
      input       sel;
      input       wr;
      input [1:0] addr;
      input [1:0] idx;
      begin
         wr_hit = sel && wr && addr == idx;
      end
   endfunction

   function guarded;
      input [6:0] hits;
      input [7:0] bp;
      begin
         guarded = |(hits & bp[6:0]);
      end
   endfunction

   wire       pgm_on   = program_control_reg[`PC_PROGRAM];
   wire       lat_on   = program_control_reg[`PC_LATCH];
   wire       locked   = module_config_reg[`MC_PROT_LOCK];
   wire       wr_mc    = wr_hit(reg_sel, reg_wr, reg_addr, `REG_MODULE_CONFIG);
   wire       wr_bp    = wr_hit(reg_sel, reg_wr, reg_addr, `REG_BLOCK_PROTECT);
   wire       wr_tc    = wr_hit(reg_sel, reg_wr, reg_addr, `REG_TEST_CONTROL);
   wire       wr_pc    = wr_hit(reg_sel, reg_wr, reg_addr, `REG_PROGRAM_CONTROL);
   wire [1:0] cur_size = size_of(program_control_reg);
   wire       test_rows = test_control_reg[`TC_ODD_ROW] | test_control_reg[`TC_EVEN_ROW];

   // ==================================================
   // Register write rules
   always @* begin
      module_config_next   = module_config_reg;
      block_protect_next   = block_protect_reg;
      test_control_next    = test_control_reg;
      program_control_next = program_control_reg;
      if (wr_mc) begin
         module_config_next[`MC_WAIT_STOP] = reg_wdata[`MC_WAIT_STOP];
         module_config_next[`MC_PUMP_CLK]  = reg_wdata[`MC_PUMP_CLK]; // [RL3]
         // Normal modes: one write only; special modes: any time
         if (!smod_n || !lock_written_reg)
            module_config_next[`MC_PROT_LOCK] = reg_wdata[`MC_PROT_LOCK]; // [RL2]
      end
      if (wr_bp && !pgm_on && !locked)
         block_protect_next = {1'b0, reg_wdata[6:0]}; // [RL4] [RL2]
      if (wr_tc && !smod_n)
         test_control_next = reg_wdata & `TC_MASK; // [RL6]
      if (!smod_n)
         test_control_next = test_control_next;
      else
         test_control_next = 8'h00; // [RL6]
      if (wr_pc) begin
         if (!pgm_on) begin
            // Any mix of these in one write is fine
            program_control_next[`PC_BYTE_SEL] = reg_wdata[`PC_BYTE_SEL]; // [RL19]
            program_control_next[`PC_ROW_SEL]  = reg_wdata[`PC_ROW_SEL]; // [RL19]
            program_control_next[`PC_ERASE]    = reg_wdata[`PC_ERASE]; // [RL19]
            program_control_next[`PC_LATCH]    = reg_wdata[`PC_LATCH]; // [RL19]
            if (!locked)
               program_control_next[`PC_BULK_PROT] = reg_wdata[`PC_BULK_PROT]; // [RL11] [RL2]
            // Enable needs latch set before and kept by this write
            program_control_next[`PC_PROGRAM] = reg_wdata[`PC_PROGRAM] & lat_on & reg_wdata[`PC_LATCH]; // [RL16]
         end else begin
            // Only the enable bit may change while voltage is applied
            program_control_next[`PC_PROGRAM] = reg_wdata[`PC_PROGRAM]; // [RL17] [RL22]
         end
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         module_config_reg   <= `MC_RESET;
         block_protect_reg   <= `BP_RESET;
         test_control_reg    <= `TC_RESET;
         program_control_reg <= `PC_RESET;
         lock_written_reg    <= 1'b0;
      end else begin
         module_config_reg   <= module_config_next;
         block_protect_reg   <= block_protect_next;
         test_control_reg    <= test_control_next;
         program_control_reg <= program_control_next;
         if (wr_mc) lock_written_reg <= 1'b1; // [RL2]
      end
   end

   // ==================================================
   // Address/data latches
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         latch_addr  <= 12'h000;
         latch_data  <= 16'h0000;
         latch_word  <= 1'b0;
         latch_valid <= 1'b0;
      end else if (!lat_on) begin
         latch_valid <= 1'b0;
      end else if (arr_wr && !pgm_on) begin // [RL18]
         latch_addr  <= arr_addr; // [RL15]
         latch_valid <= 1'b1;
         if (arr_word && !arr_addr[0]) begin
            latch_data <= arr_wdata; // [RL14]
            latch_word <= 1'b1;
         end else begin
            // Misaligned word: low byte only, word op lost
            latch_data <= {8'h00, arr_wdata[7:0]}; // [RL23]
            latch_word <= 1'b0; // [RL14]
         end
      end
   end

   // ==================================================
   // Protection and pump control
   wire [6:0] hit      = region_hit(latch_addr);
   wire [6:0] hit_word = region_hit(latch_addr | {11'h000, latch_word});
   wire       bytes_prot = guarded(hit | hit_word, block_protect_reg); // [RL5]
   wire       whole_prot = guarded(7'h7f, block_protect_reg) | program_control_reg[`PC_BULK_PROT]; // [RL11]
   wire       row_prot   = guarded(hit, block_protect_reg) | program_control_reg[`PC_BULK_PROT]; // [RL11]
   reg        prot_now;
   always @* begin
      case (cur_size)
         `ERASE_BULK: prot_now = whole_prot;
         `ERASE_ROW:  prot_now = test_rows ? whole_prot : row_prot;
         `ERASE_BYTE: prot_now = test_rows ? whole_prot : bytes_prot; // [RL14] [RL7]
         default:     prot_now = bytes_prot;
      endcase
   end

   // Stop mode drops voltage but leaves the enable bit alone
   wire pump_run = pgm_on && !in_stop && !test_control_reg[`TC_PUMP_DIS] && !prot_now; // [RL9] [RL24] [RL25]

   pump_ramp u_ramp (
      .clk          (clk),
      .rstn         (rstn),
      .clk_en       (ramp_tick),
      .pump_on      (pump_run),
      .ramp_disable (test_control_reg[`TC_RAMP_DIS]),
      .level        (ramp_level)
   );

   // ==================================================
   // Register readback and array read gate
   // Follows reg_addr without reg_sel; reads have no side effects
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata   <= 8'h00;
         arr_read_ok <= 1'b1;
      end else begin
         case (reg_addr)
            `REG_MODULE_CONFIG:   reg_rdata <= module_config_reg;
            `REG_BLOCK_PROTECT:   reg_rdata <= block_protect_reg;
            `REG_TEST_CONTROL:    reg_rdata <= test_control_reg;
            default:              reg_rdata <= program_control_reg & `PC_MASK;
         endcase
         arr_read_ok <= !lat_on; // [RL15] [RL20]
      end
   end

   // ==================================================
   // Clock controls
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         module_clk_en <= 1'b1;
         rc_osc_en     <= 1'b0;
         pump_clk_rc   <= 1'b0;
      end else begin
         module_clk_en <= !(in_wait && module_config_reg[`MC_WAIT_STOP]); // [RL1]
         pump_clk_rc   <= module_config_reg[`MC_PUMP_CLK]; // [RL3]
         rc_osc_en     <= module_config_reg[`MC_PUMP_CLK] && !in_stop; // [RL3] [RL24]
      end
   end

   // ==================================================
   // Pump and erase configuration
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pump_enable      <= 1'b0;
         pump_level       <= 4'h0;
         erase_mode       <= 1'b0;
         erase_size       <= `ERASE_NONE;
         target_protected <= 1'b0;
      end else begin
         pump_enable      <= pump_run; // [RL25]
         pump_level       <= ramp_level; // [RL10]
         erase_mode       <= program_control_reg[`PC_ERASE]; // [RL13]
         erase_size       <= cur_size; // [RL12]
         target_protected <= prot_now;
      end
   end

   // ==================================================
   // Test mode outputs
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         odd_row_bulk  <= 1'b0;
         even_row_bulk <= 1'b0;
         margin_test   <= 1'b0;
         pump_monitor  <= 1'b0;
      end else begin
         odd_row_bulk  <= test_control_reg[`TC_ODD_ROW]; // [RL7]
         even_row_bulk <= test_control_reg[`TC_EVEN_ROW]; // [RL7]
         margin_test   <= test_control_reg[`TC_MARGIN]; // [RL8]
         pump_monitor  <= test_control_reg[`TC_MONITOR];
      end
   end
endmodule // eeprom_program_erase_control

// File: tb/eectl_sva.sv
`timescale 1ns/100ps
// ==========
// Port checker
module eectl_sva (
   input wire        clk,
   input wire        rstn,
   input wire        special_mode_n,
   input wire        wait_mode,
   input wire        stop_mode,
   input wire        arr_read_ok,
   input wire [11:0] latch_addr,
   input wire [15:0] latch_data,
   input wire        latch_word,
   input wire        module_clk_en,
   input wire        rc_osc_en,
   input wire        pump_clk_rc,
   input wire        pump_enable,
   input wire        erase_mode,
   input wire [1:0]  erase_size,
   input wire        odd_row_bulk,
   input wire        even_row_bulk,
   input wire        margin_test,
   input wire        pump_monitor,
   input wire        target_protected
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Mode pins pass a 3-flop synchroniser, so allow 8 samples
   sequence s_prog_held; pump_enable ##1 pump_enable; endsequence
   sequence s_normal; special_mode_n [*8]; endsequence
   property p_latch_frozen; s_prog_held |-> $stable(latch_addr) && $stable(latch_data); endproperty
   a_latch_frozen: assert property (p_latch_frozen) else $error("latches moved while programming");
   property p_no_read; pump_enable |-> !arr_read_ok; endproperty
   a_no_read: assert property (p_no_read) else $error("array readable while programming");
   property p_pump_target; pump_enable |-> !target_protected; endproperty
   a_pump_target: assert property (p_pump_target) else $error("pump on for protected target");
   property p_stop; stop_mode [*8] |-> !pump_enable && !rc_osc_en; endproperty
   a_stop: assert property (p_stop) else $error("pump or rc running in stop");
   property p_wait_free; !wait_mode [*8] |-> module_clk_en; endproperty
   a_wait_free: assert property (p_wait_free) else $error("module clock off outside wait");
   property p_rc; rc_osc_en |-> pump_clk_rc; endproperty
   a_rc: assert property (p_rc) else $error("rc oscillator on with system pump clock");
   property p_prog_size; !erase_mode |-> erase_size == 2'h3; endproperty
   a_prog_size: assert property (p_prog_size) else $error("erase size set while programming");
   property p_test_zero; s_normal |-> !(odd_row_bulk | even_row_bulk | margin_test | pump_monitor); endproperty
   a_test_zero: assert property (p_test_zero) else $error("test bit set in normal mode");
   property p_align; latch_word |-> !latch_addr[0]; endproperty
   a_align: assert property (p_align) else $error("misaligned word latched");
endmodule // eectl_sva

// File: tb/eeprom_program_erase_control_tb_top.sv
`timescale 1ns/100ps
module eeprom_program_erase_control_tb_top;
   reg         clk, rstn, special_mode_n, wait_mode, stop_mode, ramp_tick, reg_sel, reg_wr;
   reg         arr_wr, arr_rd, arr_word, lt, w;
   reg  [1:0]  reg_addr;
   reg  [1:0]  tick_cnt = 2'h0;
   reg  [7:0]  reg_wdata, m;
   reg  [11:0] arr_addr, a;
   reg  [15:0] arr_wdata, d;
   reg  [31:0] seed, r;
   wire [7:0]  reg_rdata;
   wire [11:0] latch_addr;
   wire [15:0] latch_data;
   wire [3:0]  pump_level;
   wire [1:0]  erase_size;
   wire        arr_read_ok, latch_word, latch_valid, module_clk_en, rc_osc_en, pump_clk_rc, pump_enable;
   wire        erase_mode, odd_row_bulk, even_row_bulk, margin_test, pump_monitor, target_protected;
   integer     n_mismatch, tests_run, i;
   eeprom_program_erase_control dut (.clk, .rstn, .special_mode_n, .wait_mode, .stop_mode, .ramp_tick,
      .reg_sel, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .arr_wr, .arr_rd, .arr_addr, .arr_word,
      .arr_wdata, .arr_read_ok, .latch_addr, .latch_data, .latch_word, .latch_valid, .module_clk_en,
      .rc_osc_en, .pump_clk_rc, .pump_enable, .pump_level, .erase_mode, .erase_size, .odd_row_bulk,
      .even_row_bulk, .margin_test, .pump_monitor, .target_protected);
   // ==========
   // Helpers
   function [31:0] rnd;
      input dummy;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   function [1:0] esz;
      input [7:0] p;
      esz = !p[2] ? 2'h3 : (p[4] ? 2'h2 : {1'b0, p[3]});
   endfunction
   task chk(input [8*8:1] nm, input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk);
         #10;
      end
   endtask
   task wr(input [1:0] ad, input [7:0] dv);
      begin
         cyc(1);
         reg_sel = 1;
         reg_wr = 1;
         reg_addr = ad;
         reg_wdata = dv;
         cyc(1);
         reg_sel = 0;
         reg_wr = 0;
      end
   endtask
   task rdc(input [1:0] ad, input [7:0] e);
      begin
         cyc(1);
         reg_addr = ad;
         cyc(2);
         chk("register", reg_rdata, e);
      end
   endtask
   task aw(input [11:0] ad, input wd, input [15:0] dv);
      begin
         cyc(1);
         arr_wr = 1;
         arr_addr = ad;
         arr_word = wd;
         arr_wdata = dv;
         cyc(1);
         arr_wr = 0;
         cyc(1);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   // Divider pulse: one ramp step every four clocks
   always @(posedge clk) begin
      #10;
      tick_cnt = tick_cnt + 2'h1;
      ramp_tick = tick_cnt == 2'h0;
   end
   initial begin
      #2000000;
      n_mismatch = n_mismatch + 1;
      final_report;
   end
   // ==========
   // Main sequence
   initial begin
      seed = 32'd15206;
      n_mismatch = 0;
      tests_run = 0;
      lt = 0;
      {rstn, wait_mode, stop_mode, reg_sel, reg_wr, arr_wr, arr_rd, arr_word} = 8'h0;
      special_mode_n = 1;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      arr_addr = 12'h000;
      arr_wdata = 16'h0000;
      repeat (20) @(posedge clk);
      #10;
      rstn = 1;
      cyc(8);
      rdc(2'h0, 8'h00);
      rdc(2'h1, 8'h7f);
      rdc(2'h2, 8'h00);
      rdc(2'h3, 8'h80);
      wr(2'h1, 8'h00);
      rdc(2'h1, 8'h00);
      wr(2'h3, 8'h00);
      rdc(2'h3, 8'h00);
      wr(2'h0, 8'h85);
      cyc(8);
      chk("rc_osc", rc_osc_en, 1);
      chk("pump_clk", pump_clk_rc, 1);
      wait_mode = 1;
      cyc(8);
      chk("clk_en", module_clk_en, 0);
      wait_mode = 0;
      cyc(8);
      chk("clk_en", module_clk_en, 1);
      wr(2'h0, 8'h00);
      rdc(2'h0, 8'h04);
      chk("rc_osc", rc_osc_en, 0);
      wait_mode = 1;
      cyc(8);
      chk("clk_en", module_clk_en, 1);
      wait_mode = 0;
      wr(2'h1, 8'h7f);
      rdc(2'h1, 8'h00);
      wr(2'h3, 8'h80);
      rdc(2'h3, 8'h00);
      wr(2'h2, 8'hfc);
      rdc(2'h2, 8'h00);
      $display("test registers done");
      for (i = 0; i < 4; i = i + 1) begin
         r = rnd(0);
         m = {3'h0, r[4:2], 2'h3};
         a = r[27:16] & 12'hffe;
         w = r[5];
         d = r[15:0] ^ r[31:16];
         wr(2'h3, lt ? (m & 8'hfe) : m);
         rdc(2'h3, m & 8'hfe);
         chk("size", erase_size, esz(m));
         chk("erase", erase_mode, m[2]);
         chk("rd_ok", arr_read_ok, 0);
         aw(a, w, d);
         chk("laddr", latch_addr, a);
         chk("ldata", latch_data[7:0], d[7:0]);
         chk("lword", {latch_word, latch_valid}, {w, 1'b1});
         wr(2'h3, m);
         rdc(2'h3, m);
         chk("pump", pump_enable, 1);
         aw(~a & 12'hffe, 1, ~d);
         chk("laddr", latch_addr, a);
         wr(2'h3, m ^ 8'h9e);
         rdc(2'h3, m);
         if (i == 0) begin
            stop_mode = 1;
            cyc(8);
            chk("pump", pump_enable, 0);
            rdc(2'h3, m);
            stop_mode = 0;
            cyc(8);
            chk("pump", pump_enable, 1);
         end
         cyc(40);
         chk("level", pump_level != 4'h0, 1);
         wr(2'h3, m & 8'hfe);
         rdc(2'h3, m & 8'hfe);
         lt = !i[0];
         if (i[0]) begin
            wr(2'h3, 8'h00);
            rdc(2'h3, 8'h00);
            chk("rd_ok", arr_read_ok, 1);
         end
      end
      wr(2'h3, 8'h02);
      aw(12'h101, 1, 16'h5aa5);
      chk("lword", {latch_word, latch_addr}, 13'h0101);
      chk("ldata", latch_data, 16'h00a5);
      wr(2'h3, 8'h00);
      $display("test program done");
      special_mode_n = 0;
      cyc(8);
      wr(2'h0, 8'h00);
      rdc(2'h0, 8'h00);
      wr(2'h1, 8'h01);
      rdc(2'h1, 8'h01);
      wr(2'h2, 8'hfc);
      rdc(2'h2, 8'hfc);
      chk("test", {odd_row_bulk, even_row_bulk, margin_test, pump_monitor}, 4'hf);
      wr(2'h2, 8'h00);
      wr(2'h3, 8'h02);
      aw(12'hfc0, 0, 16'h00a5);
      wr(2'h3, 8'h03);
      cyc(2);
      chk("prot", {target_protected, pump_enable}, 2'h2);
      wr(2'h1, 8'h7f);
      rdc(2'h1, 8'h01);
      wr(2'h3, 8'h02);
      wr(2'h2, 8'h08);
      aw(12'h000, 0, 16'h0011);
      wr(2'h3, 8'h03);
      cyc(2);
      chk("level", {pump_enable, pump_level}, 5'h1f);
      wr(2'h3, 8'h02);
      wr(2'h3, 8'h00);
      wr(2'h2, 8'hfc);
      special_mode_n = 1;
      cyc(8);
      rdc(2'h2, 8'h00);
      $display("test special done");
      final_report;
   end
endmodule // eeprom_program_erase_control_tb_top
bind eeprom_program_erase_control eectl_sva chk_i (.clk, .rstn, .special_mode_n, .wait_mode, .stop_mode,
   .arr_read_ok, .latch_addr, .latch_data, .latch_word, .module_clk_en, .rc_osc_en, .pump_clk_rc,
   .pump_enable, .erase_mode, .erase_size, .odd_row_bulk, .even_row_bulk, .margin_test, .pump_monitor,
   .target_protected);
